/* tcev_pkg.sv */
package tcev_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int CNT_W  = 16;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;
   localparam int MODE_W = 4;
   localparam int IRQ_W  = 2;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CTRL1  = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_CTRL2  = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_CMP1_H = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_CMP1_L = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_CMP2_H = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_CMP2_L = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_TSEL   = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h8;

   // ---------------------------------------------------------------
   // Fields and reset values
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] CTRL1_WMASK = 8'hff;
   localparam logic [DATA_W-1:0] CTRL2_WMASK = 8'h3f;
   localparam logic [DATA_W-1:0] TSEL_WMASK  = 8'h09;
   localparam logic [DATA_W-1:0] REG_RST     = 8'h00;
   localparam logic [DATA_W-1:0] CTRL_ZERO   = 8'h00;
   localparam int                TSEL_U1_BIT = 0;
   localparam int                TSEL_U2_BIT = 3;
   localparam int                EV1_BIT     = 0;
   localparam int                EV2_BIT     = 1;
   localparam logic [CNT_W-1:0]  CNT_ZERO    = 16'h0000;

   // ---------------------------------------------------------------
   // Compare modes
   // ---------------------------------------------------------------
   localparam logic [MODE_W-1:0] MODE_OFF     = 4'h0;
   localparam logic [MODE_W-1:0] MODE_TOGGLE  = 4'h2;
   localparam logic [MODE_W-1:0] MODE_SET     = 4'h8;
   localparam logic [MODE_W-1:0] MODE_CLEAR   = 4'h9;
   localparam logic [MODE_W-1:0] MODE_SWINT   = 4'ha;
   localparam logic [MODE_W-1:0] MODE_SPECIAL = 4'hb;

   typedef enum logic {
      TCEV_TMR_A = 1'b0,
      TCEV_TMR_B = 1'b1
   } tcev_timer_type;

endpackage

/* tcev_irq.sv */
module tcev_irq
   import tcev_pkg::*;
(
   // Clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             srst_in,
   // Events and software access
   input  wire logic [IRQ_W-1:0] set_in,
   input  wire logic [IRQ_W-1:0] clr_in,
   input  wire logic [IRQ_W-1:0] mask_in,
   // Results
   output logic      [IRQ_W-1:0] status_out,
   output logic                  irq_out
);

   // A set arriving with its own clear is kept, so no event is lost.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         status_out <= '0;
      end else begin
         status_out <= (status_out & ~clr_in) | set_in;
      end
   end

   assign irq_out = |(status_out & mask_in);

   a_set_wins : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      (set_in != '0) |=> ((status_out & $past(set_in)) == $past(set_in)))
      else $error("Event flag lost against a clear.");

endmodule

/* tcev_unit.sv */
module tcev_unit
   import tcev_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk_in,
   input  wire logic              srst_in,
   // Configuration
   input  wire logic [MODE_W-1:0] mode_in,
   input  wire logic              ctrl_wr_in,
   input  wire logic              ctrl_zero_in,
   input  wire logic              cmp_wr_in,
   input  wire logic              sleep_in,
   input  wire logic [CNT_W-1:0]  cmp_value_in,
   // Selected timer
   input  wire logic [CNT_W-1:0]  count_in,
   input  wire logic              tick_in,
   // Results
   output logic                   event_out,
   output logic                   trigger_out,
   output logic                   clear_req_out,
   output logic                   pin_out,
   output logic                   pin_oe_out
);

   logic eq;
   logic prev_eq;
   logic clear_pend;

   assign eq = (count_in == cmp_value_in);

   // Sleep freezes the history so that waking does not fake an edge.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         prev_eq <= 1'b0;
      end else if (!sleep_in) begin
         prev_eq <= eq;
      end
   end

   // One event per equality, none while asleep.
   assign event_out   = eq && !prev_eq && !sleep_in && (mode_in != MODE_OFF);
   assign trigger_out = event_out && (mode_in == MODE_SPECIAL);

   // The clear waits for the timer's own clock; a compare rewrite cancels it.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         clear_pend <= 1'b0;
      end else if (ctrl_wr_in || cmp_wr_in) begin
         clear_pend <= 1'b0;
      end else if (trigger_out && !tick_in) begin
         clear_pend <= 1'b1;
      end else if (tick_in) begin
         clear_pend <= 1'b0;
      end
   end

   assign clear_req_out = clear_pend || trigger_out;

   always_ff @(posedge ref_clk_in) begin
      if (srst_in || ctrl_zero_in) begin
         pin_out <= 1'b0;
      end else if (event_out) begin
         unique case (mode_in)
            MODE_TOGGLE: pin_out <= !pin_out;
            MODE_SET:    pin_out <= 1'b1;
            MODE_CLEAR:  pin_out <= 1'b0;
            default:     pin_out <= pin_out;
         endcase
      end
   end

   // Interrupt-only and trigger modes leave the pin to its other owner.
   assign pin_oe_out = (mode_in == MODE_TOGGLE) || (mode_in == MODE_SET)
                       || (mode_in == MODE_CLEAR);

   sequence s_armed;
      trigger_out && !tick_in && !ctrl_wr_in && !cmp_wr_in;
   endsequence

   a_event_single : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      event_out |=> !event_out)
      else $error("Match event repeated on a held count.");
   a_clear_armed : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      s_armed ##1 !tick_in |-> clear_req_out)
      else $error("Pending timer clear dropped early.");
   a_cancel_rewrite : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      cmp_wr_in |=> (clear_req_out == trigger_out))
      else $error("Timer clear survived a compare rewrite.");
   a_zero_latch : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      ctrl_zero_in |=> !pin_out)
      else $error("Compare latch not low after control clear.");
   a_toggle_pin : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      event_out && (mode_in == MODE_TOGGLE) && !ctrl_zero_in
      |=> (pin_out != $past(pin_out)))
      else $error("Toggle mode did not toggle.");
   a_pin_release : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      ((mode_in == MODE_SWINT) || (mode_in == MODE_SPECIAL)) |-> !pin_oe_out)
      else $error("Pin driven in a pinless mode.");
   a_sleep_quiet : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      sleep_in |-> !event_out)
      else $error("Match event during sleep.");

endmodule

/* tcev_top.sv */
// Behaviour
// - Compare value continuously tested against timer count.
// - Every match outside off mode and sleep sets the unit's event flag.
// - Mode field chooses the match action.
// - Interrupt-only mode leaves the pin alone.
// - Trigger mode sets flag in match cycle.
// - Trigger clears timer at next timer tick.
// - Trigger clear never sets timer overflow flag.
// - Trigger mode does not drive the pin.
// - Unit two trigger starts conversion when allowed.
// - Compare rewrite before tick cancels the clear.
// - Trigger mode makes compare a timer period.
// - Zero control write forces latch low.
// - Pin select chooses unit two output pin.
// - No matching or actions during sleep.
module tcev_top
   import tcev_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk_in,
   input  wire logic              srst_in,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic [DATA_W-1:0] reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [DATA_W-1:0] reg_rdata_out,
   // Timer A
   input  wire logic [CNT_W-1:0]  timer_a_count_in,
   input  wire logic              timer_a_tick_in,
   output logic                   timer_a_clear_out,
   // Timer B
   input  wire logic [CNT_W-1:0]  timer_b_count_in,
   input  wire logic              timer_b_tick_in,
   output logic                   timer_b_clear_out,
   // Converter
   input  wire logic              adc_power_in,
   input  wire logic              adc_trigger_source_in,
   output logic                   adc_start_out,
   // System
   input  wire logic              output_pin_select_in,
   input  wire logic              sleep_in,
   // Pins
   output logic                   unit1_pin_out,
   output logic                   unit1_pin_oe_out,
   output logic                   unit2_pin_a_out,
   output logic                   unit2_pin_a_oe_out,
   output logic                   unit2_pin_b_out,
   output logic                   unit2_pin_b_oe_out,
   // Interrupt
   output logic                   irq_out
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] unit1_control;
   logic [DATA_W-1:0] unit2_control;
   logic [DATA_W-1:0] unit1_compare_high;
   logic [DATA_W-1:0] unit1_compare_low;
   logic [DATA_W-1:0] unit2_compare_high;
   logic [DATA_W-1:0] unit2_compare_low;
   logic [DATA_W-1:0] unit_timer_select;
   logic [IRQ_W-1:0]  irq_mask;
   logic [IRQ_W-1:0]  irq_status;

   logic              wr_ctrl1;
   logic              wr_ctrl2;
   logic              wr_cmp1;
   logic              wr_cmp2;
   logic              wr_status;
   logic [IRQ_W-1:0]  status_clr;
   logic [DATA_W-1:0] next_rdata;

   assign wr_ctrl1  = reg_wr_in && (reg_addr_in == ADDR_CTRL1);
   assign wr_ctrl2  = reg_wr_in && (reg_addr_in == ADDR_CTRL2);
   assign wr_cmp1   = reg_wr_in && ((reg_addr_in == ADDR_CMP1_H)
                      || (reg_addr_in == ADDR_CMP1_L));
   assign wr_cmp2   = reg_wr_in && ((reg_addr_in == ADDR_CMP2_H)
                      || (reg_addr_in == ADDR_CMP2_L));
   assign wr_status = reg_wr_in && (reg_addr_in == ADDR_STATUS);

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         unit1_control <= REG_RST;
      end else if (wr_ctrl1) begin
         unit1_control <= reg_wdata_in & CTRL1_WMASK;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         unit2_control <= REG_RST;
      end else if (wr_ctrl2) begin
         unit2_control <= reg_wdata_in & CTRL2_WMASK;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         unit1_compare_high <= REG_RST;
         unit1_compare_low  <= REG_RST;
      end else if (wr_cmp1) begin
         if (reg_addr_in == ADDR_CMP1_H) begin
            unit1_compare_high <= reg_wdata_in;
         end else begin
            unit1_compare_low <= reg_wdata_in;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         unit2_compare_high <= REG_RST;
         unit2_compare_low  <= REG_RST;
      end else if (wr_cmp2) begin
         if (reg_addr_in == ADDR_CMP2_H) begin
            unit2_compare_high <= reg_wdata_in;
         end else begin
            unit2_compare_low <= reg_wdata_in;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         unit_timer_select <= REG_RST;
      end else if (reg_wr_in && (reg_addr_in == ADDR_TSEL)) begin
         unit_timer_select <= reg_wdata_in & TSEL_WMASK;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         irq_mask <= '0;
      end else if (reg_wr_in && (reg_addr_in == ADDR_MASK)) begin
         irq_mask <= reg_wdata_in[IRQ_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_comb begin
      next_rdata = '0;
      unique case (reg_addr_in)
         ADDR_CTRL1:  next_rdata = unit1_control;
         ADDR_CTRL2:  next_rdata = unit2_control;
         ADDR_CMP1_H: next_rdata = unit1_compare_high;
         ADDR_CMP1_L: next_rdata = unit1_compare_low;
         ADDR_CMP2_H: next_rdata = unit2_compare_high;
         ADDR_CMP2_L: next_rdata = unit2_compare_low;
         ADDR_TSEL:   next_rdata = unit_timer_select;
         ADDR_STATUS: next_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
         ADDR_MASK:   next_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
         default:     next_rdata = '0;
      endcase
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in || !reg_rd_in) begin
         reg_rdata_out <= '0;
      end else begin
         reg_rdata_out <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Timer routing
   // ---------------------------------------------------------------
   tcev_timer_type   sel1;
   tcev_timer_type   sel2;
   logic [CNT_W-1:0] count1;
   logic [CNT_W-1:0] count2;
   logic             tick1;
   logic             tick2;

   assign sel1   = tcev_timer_type'(unit_timer_select[TSEL_U1_BIT]);
   assign sel2   = tcev_timer_type'(unit_timer_select[TSEL_U2_BIT]);
   assign count1 = (sel1 == TCEV_TMR_B) ? timer_b_count_in : timer_a_count_in;
   assign count2 = (sel2 == TCEV_TMR_B) ? timer_b_count_in : timer_a_count_in;
   // Ticks are the timer's own slower clock enables.
   assign tick1  = (sel1 == TCEV_TMR_B) ? timer_b_tick_in : timer_a_tick_in;
   assign tick2  = (sel2 == TCEV_TMR_B) ? timer_b_tick_in : timer_a_tick_in;

   // ---------------------------------------------------------------
   // Compare units
   // ---------------------------------------------------------------
   logic ev1;
   logic ev2;
   logic trig1;
   logic trig2;
   logic clr1;
   logic clr2;
   logic pin1;
   logic pin2;
   logic oe1;
   logic oe2;

   tcev_unit u_unit1 (
      .ref_clk_in   (ref_clk_in),
      .srst_in      (srst_in),
      .mode_in      (unit1_control[MODE_W-1:0]),
      .ctrl_wr_in   (wr_ctrl1),
      .ctrl_zero_in (wr_ctrl1 && (reg_wdata_in == CTRL_ZERO)),
      .cmp_wr_in    (wr_cmp1),
      .sleep_in     (sleep_in),
      .cmp_value_in ({unit1_compare_high, unit1_compare_low}),
      .count_in     (count1),
      .tick_in      (tick1),
      .event_out    (ev1),
      .trigger_out  (trig1),
      .clear_req_out(clr1),
      .pin_out      (pin1),
      .pin_oe_out   (oe1)
   );

   tcev_unit u_unit2 (
      .ref_clk_in   (ref_clk_in),
      .srst_in      (srst_in),
      .mode_in      (unit2_control[MODE_W-1:0]),
      .ctrl_wr_in   (wr_ctrl2),
      .ctrl_zero_in (wr_ctrl2 && (reg_wdata_in == CTRL_ZERO)),
      .cmp_wr_in    (wr_cmp2),
      .sleep_in     (sleep_in),
      .cmp_value_in ({unit2_compare_high, unit2_compare_low}),
      .count_in     (count2),
      .tick_in      (tick2),
      .event_out    (ev2),
      .trigger_out  (trig2),
      .clear_req_out(clr2),
      .pin_out      (pin2),
      .pin_oe_out   (oe2)
   );

   // The clear is a separate load request, so the timer never sees it as an
   // overflow and its overflow flag stays untouched.
   assign timer_a_clear_out = (clr1 && (sel1 == TCEV_TMR_A))
                              || (clr2 && (sel2 == TCEV_TMR_A));
   assign timer_b_clear_out = (clr1 && (sel1 == TCEV_TMR_B))
                              || (clr2 && (sel2 == TCEV_TMR_B));

   // ---------------------------------------------------------------
   // Converter start
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         adc_start_out <= 1'b0;
      end else begin
         adc_start_out <= trig2 && adc_power_in && !adc_trigger_source_in;
      end
   end

   // ---------------------------------------------------------------
   // Pins
   // ---------------------------------------------------------------
   // Direction bits live outside; oe only says this unit owns the pin.
   assign unit1_pin_out      = pin1;
   assign unit1_pin_oe_out   = oe1;
   assign unit2_pin_a_out    = pin2 && !output_pin_select_in;
   assign unit2_pin_a_oe_out = oe2 && !output_pin_select_in;
   assign unit2_pin_b_out    = pin2 && output_pin_select_in;
   assign unit2_pin_b_oe_out = oe2 && output_pin_select_in;

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   assign status_clr = wr_status ? reg_wdata_in[IRQ_W-1:0] : '0;

   tcev_irq u_irq (
      .ref_clk_in(ref_clk_in),
      .srst_in   (srst_in),
      .set_in    ({ev2, ev1}),
      .clr_in    (status_clr),
      .mask_in   (irq_mask),
      .status_out(irq_status),
      .irq_out   (irq_out)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_u2_start;
      trig2 && adc_power_in && !adc_trigger_source_in;
   endsequence

   a_match_equal : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      ev1 |-> (count1 == {unit1_compare_high, unit1_compare_low}))
      else $error("Unit one event without equality.");
   a_flag_set : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      ev1 |=> irq_status[EV1_BIT])
      else $error("Unit one flag not set on match.");
   a_trig_flag : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      trig2 |=> irq_status[EV2_BIT])
      else $error("Trigger did not set unit two flag at once.");
   a_adc_start : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      s_u2_start |=> adc_start_out)
      else $error("Conversion start missing.");
   a_adc_gate : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      (!adc_power_in || adc_trigger_source_in) |=> !adc_start_out)
      else $error("Conversion started while not allowed.");
   a_clear_route : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      trig1 && (sel1 == TCEV_TMR_A) |-> timer_a_clear_out)
      else $error("Trigger did not request timer clear.");
   a_pin_select : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      !(unit2_pin_a_oe_out && unit2_pin_b_oe_out))
      else $error("Both unit two pins driven.");
   a_read_once : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      !reg_rd_in |=> (reg_rdata_out == '0))
      else $error("Read data held past its cycle.");

   logic [MODE_W-1:0] mode1;
   logic [MODE_W-1:0] mode2;

   assign mode1 = unit1_control[MODE_W-1:0];
   assign mode2 = unit2_control[MODE_W-1:0];

   a_u2_equal : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      ev2 |-> (count2 == {unit2_compare_high, unit2_compare_low}))
      else $error("Unit two event without equality.");
   a_u2_flag : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      ev2 |=> irq_status[EV2_BIT])
      else $error("Unit two flag not set.");
   a_clear_b_route : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      trig2 && (sel2 == TCEV_TMR_B) |-> timer_b_clear_out)
      else $error("Timer B clear missing.");
   // A clear left over from an old mode would cut a free timer short.
   a_clear_a_mode : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      timer_a_clear_out |-> ((mode1 == MODE_SPECIAL) || (mode2 == MODE_SPECIAL)))
      else $error("Timer A cleared outside trigger mode.");
   a_clear_b_mode : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      timer_b_clear_out |-> ((mode1 == MODE_SPECIAL) || (mode2 == MODE_SPECIAL)))
      else $error("Timer B cleared outside trigger mode.");
   a_u1_swint_free : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      (mode1 == MODE_SWINT) |-> !unit1_pin_oe_out)
      else $error("Unit one pin driven.");
   a_u2_trig_free : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      (mode2 == MODE_SPECIAL) |-> !(unit2_pin_a_oe_out || unit2_pin_b_oe_out))
      else $error("Unit two pin driven.");
   a_pin_b_quiet : assert property (@(posedge ref_clk_in) disable iff (srst_in)
      !output_pin_select_in |-> !(unit2_pin_b_out || unit2_pin_b_oe_out))
      else $error("Unused pin not quiet.");

endmodule

/* tcev_timer_model.sv */
module tcev_timer_model #(
   parameter int DIV = 4
) (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        srst_in,
   // Clear request from the compare unit
   input  wire logic        clear_in,
   // Count, tick and overflow flag
   output logic [15:0]      count_out,
   output logic             tick_out,
   output logic             ovf_flag_out
);
   timeunit 1ns;
   timeprecision 1ns;

   int div_cnt;

   // Ticks at a quarter of the system clock and in step with it, so no match is missed.
   assign tick_out = (div_cnt == DIV - 1);

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         div_cnt <= 0;
      end else begin
         div_cnt <= tick_out ? 0 : div_cnt + 1;
      end
   end

   // A clear loads zero at the tick and is not an overflow.
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         count_out    <= 16'h0000;
         ovf_flag_out <= 1'b0;
      end else if (tick_out) begin
         if (clear_in) begin
            count_out <= 16'h0000;
         end else begin
            count_out <= count_out + 16'h0001;
            if (&count_out) begin
               ovf_flag_out <= 1'b1;
            end
         end
      end
   end
endmodule

/* timer_compare_event_unit_tb_top.sv */
module timer_compare_event_unit_tb_top
   import tcev_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk, srst, wr_s, rd_s, power, src, psel, sleep, tick_a, tick_b;
   logic        clr_a, clr_b, ovf_a, ovf_b, adc_st, irq, seen;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, v, d;
   logic [15:0] cnt_a, cnt_b;
   logic [2:0]  pin, oe;
   int          seed, err_count, check_count, t0;
   int          cyc = 0;
   logic [7:0]  wm [10] = '{8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h09, 8'h00, 8'h03, 8'h00};
   logic [3:0]  md [4] = '{MODE_TOGGLE, MODE_SET, MODE_CLEAR, MODE_SWINT};
   localparam logic [15:0] P1 = 16'h0100;

   tcev_top dut (.ref_clk_in(clk), .srst_in(srst), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .timer_a_count_in(cnt_a),
      .timer_a_tick_in(tick_a), .timer_a_clear_out(clr_a), .timer_b_count_in(cnt_b),
      .timer_b_tick_in(tick_b), .timer_b_clear_out(clr_b), .adc_power_in(power),
      .adc_trigger_source_in(src), .adc_start_out(adc_st), .output_pin_select_in(psel),
      .sleep_in(sleep), .unit1_pin_out(pin[0]), .unit1_pin_oe_out(oe[0]),
      .unit2_pin_a_out(pin[1]), .unit2_pin_a_oe_out(oe[1]), .unit2_pin_b_out(pin[2]),
      .unit2_pin_b_oe_out(oe[2]), .irq_out(irq));
   tcev_timer_model ta (.ref_clk_in(clk), .srst_in(srst), .clear_in(clr_a), .count_out(cnt_a),
      .tick_out(tick_a), .ovf_flag_out(ovf_a));
   tcev_timer_model tb (.ref_clk_in(clk), .srst_in(srst), .clear_in(clr_b), .count_out(cnt_b),
      .tick_out(tick_b), .ovf_flag_out(ovf_b));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] dv);
      @(posedge clk);
      addr  <= a;
      wdata <= dv;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, output logic [7:0] got);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 got = rdata;
   endtask

   // Returns in the first cycle in which the chosen timer shows the value.
   task automatic wait_cnt(input bit b, input logic [15:0] val);
      for (int i = 0; i < 9000; i++) begin
         @(posedge clk);
         #1;
         if ((b ? cnt_b : cnt_a) === val) return;
      end
      err_count++;
      $display("[FAIL] timer wait expected %h", val);
      close_out();
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 14352;
      {srst, wr_s, rd_s, power, src, psel, sleep} = 7'h40;
      addr  = 4'h0;
      wdata = 8'h00;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a < 10; a++) begin
         rd(a[3:0], v);
         chk("reset value", 16'h0000, v);
         if (a != 7) begin
            d = $random(seed);
            wr(a[3:0], d);
            rd(a[3:0], v);
            chk("readback", d & wm[a], v);
            wr(a[3:0], 8'h00);
         end
      end
      // Unit one sets the period of timer A.
      wr(ADDR_MASK, 8'h03);
      wr(ADDR_CMP1_H, 8'h01);
      wr(ADDR_CTRL1, {4'h0, MODE_SPECIAL});
      wait_cnt(0, P1);
      chk("u1 oe", 16'h0000, oe[0]);
      repeat (4) @(posedge clk);
      #1 chk("timer a", 16'h0000, cnt_a);
      chk("overflow a", 16'h0000, ovf_a);
      chk("irq", 16'h0001, irq);
      t0 = cyc;
      rd(ADDR_STATUS, v);
      chk("status", 16'h0001, v);
      wait_cnt(0, P1);
      wait_cnt(0, 16'h0000);
      chk("period", (P1 + 16'h0001) * 16'h0004, cyc - t0);
      wr(ADDR_STATUS, 8'h01);
      rd(ADDR_STATUS, v);
      chk("status cleared", 16'h0000, {irq, v});
      wait_cnt(0, P1);
      wr(ADDR_CMP1_L, 8'h40);
      repeat (2) @(posedge clk);
      #1 chk("no clear", P1 + 16'h0001, cnt_a);
      wr(ADDR_CTRL1, CTRL_ZERO);
      #1 chk("u1 latch", 16'h0000, pin[0]);
      // Unit two first brings timer B back to zero, then sets a short period.
      wr(ADDR_CMP2_H, 8'h08);
      wr(ADDR_CMP1_L, 8'h08);
      wr(ADDR_CMP1_H, 8'h00);
      wr(ADDR_TSEL, 8'h09);
      wr(ADDR_CTRL2, {4'h0, MODE_SPECIAL});
      wait_cnt(1, 16'h0000);
      wr(ADDR_CMP2_H, 8'h00);
      wr(ADDR_CMP2_L, 8'h20);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         power <= k[0];
         src   <= k[1];
         wait_cnt(1, 16'h0020);
         seen = 1'b0;
         repeat (3) @(posedge clk) #1 seen |= adc_st;
         chk("adc start", k[0] & ~k[1], seen);
      end
      for (int m = 0; m < 4; m++) begin
         if (m != 2) begin
            wr(ADDR_CTRL1, CTRL_ZERO);
         end
         wr(ADDR_STATUS, 8'h03);
         wr(ADDR_CTRL1, {4'h0, md[m]});
         wait_cnt(1, 16'h0008);
         repeat (3) @(posedge clk);
         #1 chk("u1 pin", (m < 2), pin[0]);
         chk("u1 oe", (m < 3), oe[0]);
         rd(ADDR_STATUS, v);
         chk("u1 event", 16'h0001, v[EV1_BIT]);
      end
      wr(ADDR_STATUS, 8'h03);
      wait_cnt(1, 16'h0000);
      @(posedge clk);
      sleep <= 1'b1;
      wait_cnt(1, 16'h0008);
      repeat (5) @(posedge clk);
      sleep <= 1'b0;
      rd(ADDR_STATUS, v);
      chk("sleep event", 16'h0000, v[EV1_BIT]);
      // Unit one takes over the period of timer B so unit two can drive its pin.
      wait_cnt(1, 16'h0000);
      wr(ADDR_CTRL1, {4'h0, MODE_SPECIAL});
      wr(ADDR_CMP2_L, 8'h04);
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         psel <= s[0];
         wr(ADDR_CTRL2, CTRL_ZERO);
         wr(ADDR_CTRL2, {4'h0, MODE_SET});
         wait_cnt(1, 16'h0004);
         repeat (2) @(posedge clk);
         #1 chk("u2 pins", {~s[0], s[0], ~s[0], s[0]}, {oe[1], oe[2], pin[1], pin[2]});
      end
      close_out();
   end
endmodule
